// ### cmpreg_top.sv
// Purpose: Control and status registers of the second analog comparator
// Assumes: Single-cycle SFR bus, write strobe and read strobe on clk
// Notes: Raw comparator output is asynchronous and is synchronised here
// Overview of operation
// - Control bit 7 enables the comparator
// - Control bit 6 reads the comparator result
// - Control bit 5 is rising-edge flag
// - Control bit 4 is falling-edge flag
// - Control bits 3-2 select positive hysteresis
// - Control bits 1-0 select negative hysteresis
// - Mux bits 6-4 select negative input
// - Mux bits 2-0 select positive input
// - Mux bits 7 and 3 read zero
// - Mode bits 7-6 read zero
// - Mode bit 5 enables rising interrupt
// - Mode bit 4 enables falling interrupt
// - Mode bits 1-0 drive response time mode
// - Edges set flags until software clears
// - Disabled comparator drives port output low
// - Port gets synchronous and raw outputs
`timescale 1ns/1ps
`include "cmpreg_params.svh"
module cmpreg_top
  import cmpreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdata,
  output logic sfrSel,
  input wire logic cmpRawIn,
  output cmpreg_core_cfg_t coreCfg,
  output logic cmpPortSync,
  output logic cmpPortAsync,
  output logic riseIrq,
  output logic fallIrq
);
  // Register state
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] mux_reg;
  logic [7:0] mux_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Synchroniser and edge detector state
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Sticky edge flags, entry 0 falling, entry 1 rising
  logic [1:0] flag_reg;
  logic [1:0] flag_next;
  logic [1:0] edgeEvt;
  logic [1:0] flagClear;
  logic [1:0] irqEn;

  // Address decode
  wire selCtrl = (sfrAddr == `CMPREG_CTRL_ADDR);
  wire selMode = (sfrAddr == `CMPREG_MODE_ADDR);
  wire selMux = (sfrAddr == `CMPREG_MUX_ADDR);
  wire wrCtrl = sfrWr && selCtrl;
  wire wrMode = sfrWr && selMode;
  wire wrMux = sfrWr && selMux;
  wire [2:0] rdSel = {selMux, selMode, selCtrl};

  // Edge events on the synchronised result
  wire riseEvt = sync2_reg && !prev_reg;
  wire fallEvt = !sync2_reg && prev_reg;
  wire cmpEnabled = ctrl_reg[`CMPREG_EN_BIT];

  // Write data fields
  wire wdEn = sfrWdata[`CMPREG_EN_BIT];
  wire [1:0] wdPosHyst = sfrWdata[`CMPREG_HYP_MSB:`CMPREG_HYP_LSB];
  wire [1:0] wdNegHyst = sfrWdata[`CMPREG_HYN_MSB:`CMPREG_HYN_LSB];
  wire wdRiseIrqEn = sfrWdata[`CMPREG_RIE_BIT];
  wire wdFallIrqEn = sfrWdata[`CMPREG_FIE_BIT];
  wire [1:0] wdSpeed = sfrWdata[`CMPREG_MD_MSB:`CMPREG_MD_LSB];
  wire [2:0] wdNegInput = sfrWdata[`CMPREG_NSEL_MSB:`CMPREG_NSEL_LSB];
  wire [2:0] wdPosInput = sfrWdata[`CMPREG_PSEL_MSB:`CMPREG_PSEL_LSB];

  // Values taken by a write; spare and read-only bits stay zero
  assign ctrl_next = {wdEn, 3'h0, wdPosHyst, wdNegHyst};

  assign mode_next = {2'h0, wdRiseIrqEn, wdFallIrqEn, 2'h0, wdSpeed};

  assign mux_next = {1'h0, wdNegInput, 1'h0, wdPosInput};

  // Register fields
  wire [1:0] posHystSel = ctrl_reg[`CMPREG_HYP_MSB:`CMPREG_HYP_LSB];
  wire [1:0] negHystSel = ctrl_reg[`CMPREG_HYN_MSB:`CMPREG_HYN_LSB];
  wire [2:0] negInputSel = mux_reg[`CMPREG_NSEL_MSB:`CMPREG_NSEL_LSB];
  wire [2:0] posInputSel = mux_reg[`CMPREG_PSEL_MSB:`CMPREG_PSEL_LSB];
  wire [1:0] responseSpeedSel = mode_reg[`CMPREG_MD_MSB:`CMPREG_MD_LSB];
  wire riseIrqEn = mode_reg[`CMPREG_RIE_BIT];
  wire fallIrqEn = mode_reg[`CMPREG_FIE_BIT];

  // Read views
  wire [7:0] ctrlView = {cmpEnabled, sync2_reg, flag_reg[1], flag_reg[0],
    posHystSel, negHystSel};

  wire [7:0] modeView = {2'h0, riseIrqEn, fallIrqEn, 2'h0,
    responseSpeedSel};

  wire [7:0] muxView = {1'h0, negInputSel, 1'h0,
    posInputSel};

  // Unmapped addresses read as zero
  wire [7:0] rdMux = ({8{rdSel[0]}} & ctrlView) |
    ({8{rdSel[1]}} & modeView) |
    ({8{rdSel[2]}} & muxView);

  assign rdata_next = sfrRd ? rdMux : rdata_reg;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
      prev_reg <= 1'h0;
    end else begin
      sync1_reg <= cmpRawIn;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign edgeEvt = {riseEvt, fallEvt};

  genvar flagIdx;
  generate
    for (flagIdx = 0; flagIdx < 2; flagIdx++) begin : g_flag
      // A written 0 clears, a written 1 leaves the flag alone
      assign flagClear[flagIdx] = wrCtrl && !sfrWdata[`CMPREG_FALL_BIT + flagIdx];

      // Set wins over a software clear in the same cycle
      assign flag_next[flagIdx] = edgeEvt[flagIdx] ||
        (flag_reg[flagIdx] && !flagClear[flagIdx]);

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          flag_reg[flagIdx] <= 1'h0;
        end else begin
          flag_reg[flagIdx] <= flag_next[flagIdx];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `CMPREG_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `CMPREG_MODE_RST;
    end else if (wrMode) begin
      mode_reg <= mode_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_reg <= `CMPREG_MUX_RST;
    end else if (wrMux) begin
      mux_reg <= mux_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Bus outputs
  assign sfrRdata = rdata_reg;
  assign sfrSel = |rdSel;

  // Settings for the analog core
  assign coreCfg = '{
    cmpOn: cmpEnabled,
    posHystSel: posHystSel,
    negHystSel: negHystSel,
    posInputSel: posInputSel,
    negInputSel: negInputSel,
    responseSpeedSel: responseSpeedSel
  };

  // Port outputs, low while disabled
  assign cmpPortSync = cmpEnabled && sync2_reg;
  assign cmpPortAsync = cmpEnabled && cmpRawIn;

  // Interrupt requests
  assign irqEn = {riseIrqEn, fallIrqEn};
  assign riseIrq = flag_reg[1] && irqEn[1];
  assign fallIrq = flag_reg[0] && irqEn[0];
endmodule // cmpreg_top

// ### cmpreg_params.svh
// Purpose: Offsets, field positions and reset values of the comparator registers
// Assumes: 8-bit special function register bus
// Notes: Definitions only
`ifndef CMPREG_PARAMS_SVH
`define CMPREG_PARAMS_SVH
`define CMPREG_CTRL_ADDR 8'h9a
`define CMPREG_MODE_ADDR 8'h9c
`define CMPREG_MUX_ADDR 8'h9f
`define CMPREG_CTRL_RST 8'h00
`define CMPREG_MODE_RST 8'h02
`define CMPREG_MUX_RST 8'h00
`define CMPREG_EN_BIT 7
`define CMPREG_OUT_BIT 6
`define CMPREG_RISE_BIT 5
`define CMPREG_FALL_BIT 4
`define CMPREG_HYP_MSB 3
`define CMPREG_HYP_LSB 2
`define CMPREG_HYN_MSB 1
`define CMPREG_HYN_LSB 0
`define CMPREG_NSEL_MSB 6
`define CMPREG_NSEL_LSB 4
`define CMPREG_PSEL_MSB 2
`define CMPREG_PSEL_LSB 0
`define CMPREG_RIE_BIT 5
`define CMPREG_FIE_BIT 4
`define CMPREG_MD_MSB 1
`define CMPREG_MD_LSB 0
`endif

// ### cmpreg_pkg.sv
// Purpose: Types shared by the comparator register bank
// Assumes: Nothing beyond the header
// Notes: Carries the settings that go to the analog core
package cmpreg_pkg;
  typedef struct packed {
    logic cmpOn;
    logic [1:0] posHystSel;
    logic [1:0] negHystSel;
    logic [2:0] posInputSel;
    logic [2:0] negInputSel;
    logic [1:0] responseSpeedSel;
  } cmpreg_core_cfg_t;
endpackage

// ### cmpreg_checker.sv
// Purpose: Port assertions for the comparator register bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to cmpreg_top
`timescale 1ns/1ps
module cmpreg_checker
  import cmpreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdata,
  input wire logic cmpRawIn,
  input wire cmpreg_core_cfg_t coreCfg,
  input wire logic cmpPortSync,
  input wire logic cmpPortAsync,
  input wire logic riseIrq,
  input wire logic sfrSel,
  input wire logic fallIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wrC = sfrWr && sfrAddr == 8'h9a;
  wire wrD = sfrWr && sfrAddr == 8'h9c;
  sequence s_onHi; (cmpRawIn && coreCfg.cmpOn)[*5]; endsequence
  property p_ctrl; wrC |=> {coreCfg.cmpOn, coreCfg.posHystSel, coreCfg.negHystSel}
    == $past({sfrWdata[7], sfrWdata[3:0]}); endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl fields");
  property p_mux; sfrWr && sfrAddr == 8'h9f |=> {coreCfg.negInputSel, coreCfg.posInputSel}
    == $past({sfrWdata[6:4], sfrWdata[2:0]}); endproperty
  a_mux: assert property (p_mux) else $error("mux fields");
  property p_md; wrD |=> coreCfg.responseSpeedSel == $past(sfrWdata[1:0]); endproperty
  a_md: assert property (p_md) else $error("speed mode");
  property p_rdM; sfrRd && sfrAddr == 8'h9f |=> !sfrRdata[7] && !sfrRdata[3]; endproperty
  a_rdM: assert property (p_rdM) else $error("mux spare bits");
  property p_rdD; sfrRd && sfrAddr == 8'h9c |=> sfrRdata[7:6] == 2'h0; endproperty
  a_rdD: assert property (p_rdD) else $error("mode spare bits");
  property p_as; cmpPortAsync == (coreCfg.cmpOn && cmpRawIn); endproperty
  a_as: assert property (p_as) else $error("raw port");
  property p_sy; s_onHi |-> cmpPortSync; endproperty
  a_sy: assert property (p_sy) else $error("sync port");
  property p_off; !coreCfg.cmpOn && !$past(coreCfg.cmpOn) |-> !cmpPortSync; endproperty
  a_off: assert property (p_off) else $error("port not low");
  property p_st; riseIrq && !wrC && !wrD |=> riseIrq; endproperty
  a_st: assert property (p_st) else $error("flag dropped");
  property p_unm; sfrRd && !sfrSel |=> sfrRdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_fst; fallIrq && !wrC && !wrD |=> fallIrq; endproperty
  a_fst: assert property (p_fst) else $error("fall flag dropped");
endmodule // cmpreg_checker
bind cmpreg_top cmpreg_checker u_chk(.*);

// ### cmpreg_core_model.sv
// Purpose: Behavioural analog comparator core
// Assumes: diffPos is 1 while the plus input is above the minus input
// Notes: Output delay grows with the response mode
`timescale 1ns/1ps
module cmpreg_core_model
  import cmpreg_pkg::*;
(
  input wire cmpreg_core_cfg_t cfg,
  input wire logic diffPos,
  output logic cmpRawIn
);
  int dly[4] = '{100, 175, 320, 1050};
  initial cmpRawIn = 1'b0;
  always @(diffPos) cmpRawIn <= #(dly[cfg.responseSpeedSel]) diffPos;
endmodule // cmpreg_core_model

// ### cmpreg_tb.sv
// Purpose: Self-checking bench for the comparator register bank
// Assumes: Read data shows one cycle after the read strobe
// Notes: Core model stands in for the analog comparator
`timescale 1ns/1ps
module testbench;
  import cmpreg_pkg::*;
  logic clk = 0, rst_b = 0, sfrWr = 0, sfrRd = 0, diffPos = 0, rdLate = 0;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, d, expQ[$];
  logic sfrSel, cmpRawIn, cmpPortSync, cmpPortAsync, riseIrq, fallIrq;
  cmpreg_core_cfg_t coreCfg;
  int failCount = 0, testsRun = 0, cyc = 0;
  cmpreg_top dut(.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdata(sfrRdata), .sfrSel(sfrSel), .cmpRawIn(cmpRawIn),
    .coreCfg(coreCfg), .cmpPortSync(cmpPortSync), .cmpPortAsync(cmpPortAsync),
    .riseIrq(riseIrq), .fallIrq(fallIrq));
  cmpreg_core_model core(.cfg(coreCfg), .diffPos(diffPos), .cmpRawIn(cmpRawIn));
  initial forever #50 clk = ~clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    testsRun++;
    if (g !== e) begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task endSim;
    $display("checks=%0d mismatches=%0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) {sfrAddr, sfrWdata, sfrWr} = {a, v, 1'b1};
    @(negedge clk) sfrWr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) {sfrAddr, sfrRd} = {a, 1'b1};
    expQ.push_back(e);
    @(negedge clk) sfrRd = 0;
  endtask
  always @(posedge clk) rdLate <= sfrRd;
  always @(negedge clk) if (rdLate) chk(sfrRdata, expQ.pop_front());
  always @(posedge clk) if (++cyc == 2000) begin failCount++; endSim; end
  initial begin
    d = 8'($urandom(47));
    repeat (6) @(negedge clk);
    rst_b = 1;
    rd(8'h9a, 8'h00);
    rd(8'h9c, 8'h02);
    rd(8'h9f, 8'h00);
    rd(8'h9b, 8'h00);
    chk({7'h0, sfrSel}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = {1'($urandom), 3'(i % 5), 1'($urandom), 1'b0, 2'(i)};
      wr(8'h9a, d);
      rd(8'h9a, d & 8'h8f);
      wr(8'h9f, d);
      rd(8'h9f, d & 8'h77);
      wr(8'h9c, d);
      rd(8'h9c, d & 8'h33);
    end
    $display("test fields done");
    wr(8'h9c, 8'h30);
    wr(8'h9a, 8'h80);
    diffPos = 1;
    repeat (10) @(negedge clk);
    rd(8'h9a, 8'he0);
    chk({7'h0, riseIrq}, 8'h01);
    chk({6'h0, cmpPortSync, cmpPortAsync}, 8'h03);
    chk({7'h0, sfrSel}, 8'h01);
    diffPos = 0;
    repeat (10) @(negedge clk);
    rd(8'h9a, 8'hb0);
    chk({7'h0, fallIrq}, 8'h01);
    wr(8'h9a, 8'ha0);
    rd(8'h9a, 8'ha0);
    wr(8'h9c, 8'h00);
    chk({6'h0, riseIrq, fallIrq}, 8'h00);
    wr(8'h9a, 8'h00);
    diffPos = 1;
    repeat (10) @(negedge clk);
    chk({6'h0, cmpPortSync, cmpPortAsync}, 8'h00);
    rd(8'h9a, 8'h60);
    $display("test edges done");
    endSim;
  end
endmodule // testbench
